// ### verilog/rtc_host_defs.svh
`ifndef RTC_HOST_DEFS_SVH
`define RTC_HOST_DEFS_SVH

// ----------------------------------------
// Bus addresses and word pointer limits
// ----------------------------------------
`define CTRL_SPACE_ID 7'h6f
`define SRAM_SPACE_ID 7'h57
`define DIR_READ 1'b1
`define DIR_WRITE 1'b0
`define CTRL_SPACE_LAST 8'h2f
`define SRAM_SPACE_LAST 8'h7f
`define POINTER_RESET 8'h00
`define BYTE_BITS 4'd8
`define ACK_LEVEL 1'b0

// ----------------------------------------
// Serial clock timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define LINK_PERIOD_NS 2500
`define QUARTER_CYCLES ((`LINK_PERIOD_NS / 4) / `CLK_PERIOD_NS)

`endif

// ### verilog/rtc_host_pkg.sv
package rtc_host_pkg;

    // Commands accepted from the user side.
    typedef enum logic [1:0] {
        cmd_write,
        cmd_read_random,
        cmd_read_current
    } cmd_t;

    // Controller sequence states.
    typedef enum logic [3:0] {
        st_idle,
        st_start,
        st_send,
        st_send_ack,
        st_recv,
        st_recv_ack,
        st_restart,
        st_stop,
        st_done
    } state_t;

endpackage

// ### verilog/bit_phase_timer.sv
`include "rtc_host_defs.svh"

// ----------------------------------------
// Quarter period tick generator
// ----------------------------------------
module bit_phase_timer import rtc_host_pkg::*; #(
    parameter int QUARTER = `QUARTER_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Run control and tick.
    input wire logic run,
    output logic tick
);

    initial begin
        if (QUARTER < 2) $error("QUARTER must be at least 2");
    end

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    wire at_end = (cnt_q == 16'(QUARTER - 1));

    assign cnt_d = (!run || at_end) ? 16'h0000 : cnt_q + 16'h0001;
    assign tick = run && at_end;

    // Counter restarts while idle so every phase is full length.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // bit_phase_timer

// ### verilog/rtc_i2c_host.sv
// Overview of operation
// - Every byte is shifted most significant bit first.
// - Data changes only while clock is low, except start and stop.
// - Each transaction ends with stop, returning the device to standby.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Host acknowledges each read byte while it wants more.
// - Address bit zero selects direction: one read, zero write.
// - One word address byte follows, else the device counter is used.
// - Random read uses the same device address in both phases.
// - Write is start, address, word address, one data, stop.
// - Random read: start, address write, word, restart, address read.
// - Device sends while host acknowledges; host stops after last byte.
`include "rtc_host_defs.svh"

module rtc_i2c_host import rtc_host_pkg::*; #(
    parameter int MAX_READ = 256
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // User command port.
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cmd_t cmd_op,
    input wire logic cmd_sram,
    input wire logic [7:0] cmd_word,
    input wire logic [7:0] cmd_data,
    input wire logic [8:0] cmd_count,
    // User read data and completion.
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    output logic nack_err,
    output logic busy,
    // Serial clock pin (open drain).
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Serial data pin (open drain).
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    initial begin
        if (MAX_READ < 1 || MAX_READ > 256) $error("MAX_READ must be 1 to 256");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sda_sync_q;
    logic [1:0] scl_sync_q;

    // Two stages before any logic reads the pins.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_sync_q <= {scl_sync_q[0], scl_i};
        end
    end

    wire sda_in = sda_sync_q[1];
    wire scl_in = scl_sync_q[1];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    state_t state_q, state_d;
    cmd_t op_q;
    logic [1:0] phase_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [1:0] byte_idx_q;
    logic [8:0] left_q;
    logic sram_q, reading_q;
    logic [7:0] word_q, data_q;
    logic scl_low_q, sda_low_q, ack_q;
    logic rd_valid_q, done_q, nack_q;
    logic [7:0] rd_data_q;

    wire tick;

    bit_phase_timer #(
        .QUARTER(`QUARTER_CYCLES)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .run(state_q != st_idle),
        .tick(tick)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [6:0] dev_id = sram_q ? `SRAM_SPACE_ID : `CTRL_SPACE_ID;
    wire [7:0] addr_w = {dev_id, `DIR_WRITE};
    wire [7:0] addr_r = {dev_id, `DIR_READ};
    wire last_phase = (phase_q == 2'd3);
    wire bit_end = tick && last_phase;
    wire last_bit = (bit_q == `BYTE_BITS - 4'd1);
    wire scl_held = !scl_low_q && !scl_in;                                        // Released but held low by the far end.
    wire ack_seen = (ack_q == `ACK_LEVEL);                                       // Level taken mid high.
    wire more_wanted = (left_q > 9'd1);
    wire read_next = (op_q == cmd_read_current && byte_idx_q == 2'd0) ||
                     (op_q == cmd_read_random && byte_idx_q == 2'd2);             // Data follows this ack.

    // Byte order of each transfer: write sends three, reads send one or three.
    wire [7:0] next_byte = (byte_idx_q == 2'd0) ? addr_w :
                           (byte_idx_q == 2'd1) ? word_q : data_q;
    assign cmd_ready = (state_q == st_idle);
    wire accept = cmd_valid && cmd_ready;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (accept) state_d = st_start;
            end
            st_start: begin
                if (bit_end) state_d = st_send;
            end
            st_send: begin
                if (bit_end && last_bit) state_d = st_send_ack;
            end
            st_send_ack: begin
                if (bit_end) begin
                    if (!ack_seen) state_d = st_stop;                              // Abort on refusal.
                    else if (reading_q || read_next) state_d = st_recv;
                    else if (op_q == cmd_read_random && byte_idx_q == 2'd1) state_d = st_restart;
                    else if (byte_idx_q == 2'd2) state_d = st_stop;
                    else state_d = st_send;
                end
            end
            st_recv: begin
                if (bit_end && last_bit) state_d = st_recv_ack;
            end
            st_recv_ack: begin
                if (bit_end) state_d = more_wanted ? st_recv : st_stop;
            end
            st_restart: begin
                if (bit_end) state_d = st_send;
            end
            st_stop: begin
                if (bit_end) state_d = st_done;
            end
            st_done: state_d = st_idle;
            default: state_d = st_idle;
        endcase
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= st_idle;
        end else if (!(scl_held && tick)) begin
            state_q <= state_d;
        end
    end

    // Phase counter: each bit is four quarters, clock high in quarters 1 and 2, except start (quarters 0 to 2) and stop (quarters 1 to 3).
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q <= 2'd0;
        end else if (state_q == st_idle) begin
            phase_q <= 2'd0;
        end else if (tick && !scl_held) begin
            phase_q <= phase_q + 2'd1;
        end
    end

    // Command capture.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_q <= cmd_write;
            sram_q <= 1'b0;
            word_q <= `POINTER_RESET;
            data_q <= 8'h00;
        end else if (accept) begin
            op_q <= cmd_op;
            sram_q <= cmd_sram;
            word_q <= cmd_word;
            data_q <= cmd_data;
        end
    end

    // Bit and byte bookkeeping, shift register MSB first.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bit_q <= 4'd0;
            shift_q <= 8'h00;
            byte_idx_q <= 2'd0;
            reading_q <= 1'b0;
            left_q <= 9'd0;
        end else if (accept) begin
            byte_idx_q <= 2'd0;
            reading_q <= 1'b0;
            left_q <= (cmd_count == 9'd0) ? 9'd1 : cmd_count;
            shift_q <= (cmd_op == cmd_read_current) ? {cmd_sram ? `SRAM_SPACE_ID : `CTRL_SPACE_ID, `DIR_READ}
                                                    : {cmd_sram ? `SRAM_SPACE_ID : `CTRL_SPACE_ID, `DIR_WRITE};
            bit_q <= 4'd0;
        end else if (bit_end && !scl_held) begin
            case (state_q)
                st_start, st_restart: bit_q <= 4'd0;
                st_send: begin
                    bit_q <= bit_q + 4'd1;
                    shift_q <= {shift_q[6:0], 1'b0};
                end
                st_recv: begin
                    bit_q <= last_bit ? 4'd0 : bit_q + 4'd1;
                end
                st_send_ack: begin
                    bit_q <= 4'd0;
                    if (op_q == cmd_read_current && byte_idx_q == 2'd0) reading_q <= 1'b1;
                    if (op_q == cmd_read_random && byte_idx_q == 2'd1) begin
                        shift_q <= addr_r;
                        byte_idx_q <= 2'd2;
                    end else if (op_q == cmd_read_random && byte_idx_q == 2'd2) begin
                        reading_q <= 1'b1;
                    end else begin
                        byte_idx_q <= byte_idx_q + 2'd1;
                        shift_q <= (byte_idx_q == 2'd0) ? word_q : data_q;
                    end
                end
                st_recv_ack: left_q <= left_q - 9'd1;
                default: bit_q <= bit_q;
            endcase
        end else if (state_q == st_recv && tick && phase_q == 2'd1) begin
            shift_q <= {shift_q[6:0], sda_in};                                   // Sample mid high.
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Line levels per state and quarter; data changes happen in quarter 0 (clock low), start and stop edges in quarter 2.
    logic scl_low_d, sda_low_d;
    always_comb begin
        scl_low_d = (phase_q == 2'd0) || (phase_q == 2'd3);
        sda_low_d = 1'b0;
        case (state_q)
            st_idle: begin
                scl_low_d = 1'b0;
                sda_low_d = 1'b0;
            end
            st_start: begin
                scl_low_d = (phase_q == 2'd3);
                sda_low_d = (phase_q >= 2'd2);                                   // Falls while clock high.
            end
            st_restart: begin
                scl_low_d = (phase_q == 2'd0) || (phase_q == 2'd3);
                sda_low_d = (phase_q >= 2'd2);
            end
            st_send: sda_low_d = !shift_q[7];
            st_send_ack: sda_low_d = 1'b0;                                       // Release for device ack.
            st_recv: sda_low_d = 1'b0;
            st_recv_ack: sda_low_d = more_wanted;
            st_stop: begin
                scl_low_d = (phase_q == 2'd0);
                sda_low_d = (phase_q <= 2'd1);                                   // Rises while clock high.
            end
            st_done: begin
                scl_low_d = 1'b0;
                sda_low_d = 1'b0;
            end
            default: begin
                scl_low_d = 1'b0;
                sda_low_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
        end
    end

    assign scl_o = 1'b0;
    assign scl_oe = scl_low_q;
    assign sda_o = 1'b0;
    assign sda_oe = sda_low_q;

    // ----------------------------------------
    // User results
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            ack_q <= 1'b1;
        end else begin
            rd_valid_q <= (state_q == st_recv) && bit_end && last_bit;
            if ((state_q == st_recv) && bit_end && last_bit) rd_data_q <= shift_q;
            done_q <= (state_q == st_done);
            if (accept) nack_q <= 1'b0;
            else if (state_q == st_send_ack && bit_end && !ack_seen) nack_q <= 1'b1;
            if (state_q == st_send_ack && tick && phase_q == 2'd1) ack_q <= sda_in;    // Sample mid high.
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign done = done_q;
    assign nack_err = nack_q;
    assign busy = !cmd_ready;

endmodule // rtc_i2c_host

// ### verif/rtc_host_sva.sv
// ----------------------------------------
// Port checker for the serial host
// ----------------------------------------
module rtc_host_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Command handshake.
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic busy,
    // Completion.
    input wire logic rd_valid,
    input wire logic done,
    input wire logic nack_err,
    // Line enables.
    input wire logic scl_oe,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Line, handshake and completion relations.
    lines_reset_a: assert property ($fell(reset) |-> !sda_oe && !scl_oe && cmd_ready)
        else $error("lines not released after reset");
    start_soon_a: assert property (cmd_valid && cmd_ready |-> ##[1:300] (sda_oe && !scl_oe))
        else $error("no start after accept");
    edge_skew_a: assert property ($changed(sda_oe) |-> !$changed(scl_oe))
        else $error("data and clock moved together");
    low_phase_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
        else $error("clock low phase too short");
    stop_released_a: assert property (done |-> !sda_oe && !scl_oe)
        else $error("lines held after stop");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    standby_ready_a: assert property (done |-> ##[0:2] (cmd_ready && !busy))
        else $error("not idle after done");
    rd_pulse_a: assert property (rd_valid |=> !rd_valid)
        else $error("read strobe longer than one cycle");
    nack_end_a: assert property ($rose(nack_err) |-> ##[0:400] done)
        else $error("refused transfer not ended");

    // Main scenarios reached.
    cover property (rd_valid);
    cover property ($rose(nack_err));
    cover property (done && !nack_err);
endmodule // rtc_host_sva

bind rtc_i2c_host rtc_host_sva chk (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .busy(busy), .rd_valid(rd_valid), .done(done), .nack_err(nack_err), .scl_oe(scl_oe), .sda_oe(sda_oe));

// ### verif/rtc_dev_model.sv
`include "rtc_host_defs.svh"

// ----------------------------------------
// Behavioural clock and calendar device
// ----------------------------------------
module rtc_dev_model (
    // Bus lines as seen on the wires.
    input wire logic scl,
    input wire logic sda,
    // Main power present.
    input wire logic powered,
    // Data line pull-down.
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [7:0] ptr_q;
    logic [7:0] b;
    logic sram_q;
    logic go;
    logic m_ack;

    // Factory contents load, the pointer clears and the data line is released at power-up.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        ptr_q = `POINTER_RESET;
        sda_pull = 1'b0;
        go = 1'b0;
    end

    // A start counts only with main power; a stop always ends the transfer.
    always @(negedge sda) begin
        if (scl === 1'b1 && powered === 1'b1) begin
            go = 1'b1;
            disable serve;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            go = 1'b0;
            sda_pull = 1'b0;
            disable serve;
        end
    end

    task automatic get_byte();
        repeat (8) begin
            @(posedge scl);
            b = {b[6:0], sda};
        end
        @(negedge scl);
    endtask

    task automatic ack();
        sda_pull = 1'b1;
        @(negedge scl);
        sda_pull = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~v[i];
            @(negedge scl);
        end
        sda_pull = 1'b0;
        @(posedge scl);
        m_ack = (sda === `ACK_LEVEL);
        @(negedge scl);
    endtask

    task automatic step();
        if (ptr_q == (sram_q ? `SRAM_SPACE_LAST : `CTRL_SPACE_LAST)) ptr_q = `POINTER_RESET;
        else ptr_q = ptr_q + 8'h01;
    endtask

    // One transfer from start to stop; a repeated start begins it afresh.
    always begin : serve
        wait (go);
        go = 1'b0;
        get_byte();
        if (b[7:1] != `CTRL_SPACE_ID && b[7:1] != `SRAM_SPACE_ID) wait (go);
        sram_q = (b[7:1] == `SRAM_SPACE_ID);
        ack();
        if (b[0] == `DIR_WRITE) begin
            get_byte();
            ack();
            ptr_q = b;
            get_byte();
            ack();
            mem[{sram_q, ptr_q[6:0]}] = b;
            step();
        end else begin
            m_ack = 1'b1;
            while (m_ack) begin
                put_byte(mem[{sram_q, ptr_q[6:0]}]);
                step();
            end
        end
    end
endmodule // rtc_dev_model

// ### verif/test_rtc_i2c_slave_port.sv
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end

module test_rtc_i2c_slave_port import rtc_host_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, cmd_valid, cmd_ready, cmd_sram, rd_valid, done, nack_err, busy, powered;
    logic scl_oe, sda_oe, dev_pull;
    cmd_t cmd_op;
    logic [7:0] cmd_word, cmd_data, rd_data;
    logic [8:0] cmd_count;
    wire scl_w = ~scl_oe;
    wire sda_w = ~(sda_oe | dev_pull);
    logic [7:0] got [$];
    int error_cnt = 0;
    int check_count = 0;

    // Host under test and the device on the pulled-up wires.
    rtc_i2c_host uut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_sram(cmd_sram), .cmd_word(cmd_word), .cmd_data(cmd_data), .cmd_count(cmd_count), .rd_valid(rd_valid),
        .rd_data(rd_data), .done(done), .nack_err(nack_err), .busy(busy), .scl_i(scl_w), .scl_o(),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
    rtc_dev_model dev (.scl(scl_w), .sda(sda_w), .powered(powered), .sda_pull(dev_pull));

    // Clock and collection of received bytes.
    always #10 clk = ~clk;
    always @(negedge clk) begin
        if (rd_valid === 1'b1) got.push_back(rd_data);
    end

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic issue(input cmd_t op, input logic sr, input logic [7:0] w, input logic [7:0] d,
        input logic [8:0] n);
        int k;
        @(negedge clk);
        got.delete();
        cmd_op = op;
        cmd_sram = sr;
        cmd_word = w;
        cmd_data = d;
        cmd_count = n;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(negedge clk);
            k++;
        end
        `CHK("done", 1'b1, done)
    endtask

    task automatic t_first_read();
        issue(cmd_read_current, 1'b0, 8'h00, 8'h00, 9'd2);
        `CHK("count", 2, got.size())
        `CHK("byte0", 8'h5a, got[0])
        `CHK("byte1", 8'h5b, got[1])
        `CHK("nack", 1'b0, nack_err)
    endtask

    task automatic t_backup();
        powered = 1'b0;
        issue(cmd_write, 1'b1, 8'h10, 8'h77, 9'd1);
        `CHK("nack", 1'b1, nack_err)
        powered = 1'b1;
    endtask

    task automatic t_write_read();
        issue(cmd_write, 1'b1, 8'h7e, 8'h3c, 9'd1);
        `CHK("nack", 1'b0, nack_err)
        issue(cmd_read_random, 1'b1, 8'h7e, 8'h00, 9'd3);
        `CHK("count", 3, got.size())
        `CHK("byte0", 8'h3c, got[0])
        `CHK("byte1", 8'ha5, got[1])
        `CHK("byte2", 8'hda, got[2])
    endtask

    task automatic t_ctrl_wrap();
        issue(cmd_read_random, 1'b0, 8'h2e, 8'h00, 9'd3);
        `CHK("byte0", 8'h74, got[0])
        `CHK("byte1", 8'h75, got[1])
        `CHK("byte2", 8'h5a, got[2])
        issue(cmd_read_current, 1'b0, 8'h00, 8'h00, 9'd0);
        `CHK("count", 1, got.size())
        `CHK("next", 8'h5b, got[0])
    endtask

    // Bounded run guard: about twice the expected length of all scenarios.
    initial begin
        #1000000;
        error_cnt++;
        results();
    end

    // Reset and scenario sequence.
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = cmd_write;
        cmd_sram = 1'b0;
        cmd_word = 8'h00;
        cmd_data = 8'h00;
        cmd_count = 9'h000;
        powered = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_first_read();
        t_backup();
        t_write_read();
        t_ctrl_wrap();
        results();
    end
endmodule // test_rtc_i2c_slave_port
